// >>> inc/tmr_consts.svh
// Purpose: Constants for the timer 2 / high speed PWM block
// Assumes: Wishbone word index = byte address / 4
// Notes:   Register index values, field positions and reset values
//
// Notes on behaviour
// - Match request forwarded only while match enable is set.
// - Match flag, request bit 3, cleared by hardware on service entry.
// - Overflow request forwarded only while overflow enable is set.
// - Overflow flag, request bit 2, cleared by hardware on service entry.
// - Mode bit: 0 interval with toggle output, 1 capture with overflow.
// - Writing 1 to clear bit clears counter; bit reads back 0.
// - Counter compares against buffer copy, loaded on clear, match, overflow.
// - Interval match toggles output, raises match request, clears counter.
// - Capture edge copies counter into compare data, then clears counter.
// - Capture mode raises overflow request at each 8-bit wrap.
// - PWM select bit switches shared counter into PWM mode.
// - PWM mode drives two outputs with 10-bit duty, one shared period.
// - PWM period is 10-bit value plus one source clocks.
// - Duty is value plus one clocks; A uses bits 3:2, B bits 5:4.
// - Polarity 0 makes duty portion low, 1 makes it high.
// - New duty applies after current period; period change keeps duty time.
// - Duty equal to period gives constant polarity level.
// - Duty zero gives constant inverse of polarity level.
// - High-bits register: period 1:0, A 3:2, B 5:4; resets to ones.
// - Duty low registers hold low eight bits of each duty.
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define TMR_IDX_CTRL     8'hb6
`define TMR_IDX_CMP      8'hb7
`define TMR_IDX_CNT      8'hb8
`define TMR_IDX_PWMCTRL  8'hce
`define TMR_IDX_HBITS    8'hcf
`define TMR_IDX_DUTY_A   8'hd0
`define TMR_IDX_DUTY_B   8'hd1
`define TMR_IDX_IRQ      8'hd2
`define TMR_IDX_IRQEN    8'hd3

`define TMR_CTRL_MODE    5
`define TMR_CTRL_CLR     4
`define TMR_PWM_POL_B    6
`define TMR_PWM_POL_A    5
`define TMR_PWM_SEL      4
`define TMR_IRQ_MATCH    3
`define TMR_IRQ_OVF      2

`define TMR_RST_CTRL     8'h00
`define TMR_RST_HBITS    8'hff
`define TMR_CNT_MAX      8'hff

`define TMR_CS_STOP      4'h0
`define TMR_CS_EXT_RISE  4'h5
`define TMR_CS_EXT_FALL  4'h6

`endif

// >>> inc/tmr_pkg.sv
// Purpose: Types for the timer 2 / high speed PWM block
// Assumes: Constants live in tmr_consts.svh
// Notes:   Whole module state is one packed struct
package tmr_pkg;

   typedef logic [9:0] tmr_cnt_t;

   typedef struct packed {
      logic       ack;
      logic [7:0] rdat;
      logic [3:0] cs;
      logic       mode;
      logic [7:0] cmp;
      logic [7:0] cmp_buf;
      tmr_cnt_t   cnt;
      tmr_cnt_t   pre;
      logic       ext_q;
      logic       cap_q;
      logic [7:0] hbits;
      logic [7:0] duty_a_lo;
      logic [7:0] duty_b_lo;
      tmr_cnt_t   duty_a_act;
      tmr_cnt_t   duty_b_act;
      logic       pol_a;
      logic       pol_b;
      logic       pwm_en;
      logic       mflag;
      logic       oflag;
      logic       men;
      logic       oen;
      logic       toggle;
      logic       pwm_a;
      logic       pwm_b;
      logic       mreq;
      logic       oreq;
   } tmr_state_s;

endpackage

// >>> core/tmr_top.sv
// Purpose: 8-bit timer 2 (interval / capture) sharing its counter with a
//          two-channel 10-bit high speed PWM, Wishbone classic slave
// Assumes: All pin inputs synchronous to clk; 32-bit bus, data in low byte
// Notes:   Interrupt controller is outside; it pulses the ack inputs
`timescale 1ns/1ps
`include "tmr_consts.svh"

module tmr_top
   import tmr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_count_clock,
   input  wire logic        capture_input,
   input  wire logic        match_irq_ack,
   input  wire logic        overflow_irq_ack,
   output logic             match_toggle_out,
   output logic             pwm_a_out,
   output logic             pwm_b_out,
   output logic             match_irq_req,
   output logic             overflow_irq_req
);

   tmr_state_s st;
   tmr_state_s next_st;

   logic       req;
   logic       wr;
   logic       mapped;
   logic [7:0] idx;
   logic       tick;
   logic       ext_rise;
   logic       ext_fall;
   logic       cap_edge;
   tmr_cnt_t   div_mask;
   tmr_cnt_t   period;
   tmr_cnt_t   duty_a_new;
   tmr_cnt_t   duty_b_new;
   logic       act_a;
   logic       act_b;
   logic       clr_req;
   logic       match_ev;
   logic       ovf_ev;

   always_comb begin
      next_st = st;

      // Bus decode: one wait state, ack for one cycle only
      req    = wb_cyc_i & wb_stb_i & ~st.ack;
      idx    = wb_adr_i[9:2];
      wr     = req & wb_we_i & wb_sel_i[0] & (wb_adr_i[11:10] == 2'b00);
      mapped = 1'b0;
      case (idx)
         `TMR_IDX_CTRL,
         `TMR_IDX_CMP,
         `TMR_IDX_CNT,
         `TMR_IDX_PWMCTRL,
         `TMR_IDX_HBITS,
         `TMR_IDX_DUTY_A,
         `TMR_IDX_DUTY_B,
         `TMR_IDX_IRQ,
         `TMR_IDX_IRQEN: begin
            mapped = (wb_adr_i[11:10] == 2'b00);
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
      wr = wr & mapped;

      // Free-running prescaler; a division tick is all-ones in the mask bits
      next_st.pre = st.pre + 10'h001;
      ext_rise    = ext_count_clock & ~st.ext_q;
      ext_fall    = ~ext_count_clock & st.ext_q;
      cap_edge    = capture_input & ~st.cap_q;
      next_st.ext_q = ext_count_clock;
      next_st.cap_q = capture_input;

      div_mask = 10'h000;
      tick     = 1'b0;
      case (st.cs)
         `TMR_CS_EXT_RISE: tick = ext_rise;
         `TMR_CS_EXT_FALL: tick = ext_fall;
         4'h8: tick = 1'b1;
         4'h9: div_mask = 10'h001;
         4'ha: div_mask = 10'h003;
         4'hb: div_mask = 10'h007;
         4'hc: div_mask = 10'h00f;
         4'hd: div_mask = 10'h03f;
         4'he: div_mask = 10'h0ff;
         4'hf: div_mask = 10'h3ff;
         default: tick = 1'b0;
      endcase
      if (st.cs[3] && st.cs != 4'h8) begin
         tick = ((st.pre & div_mask) == div_mask);
      end

      // PWM quantities
      period     = {st.hbits[1:0], st.cmp};
      duty_a_new = {st.hbits[3:2], st.duty_a_lo};
      duty_b_new = {st.hbits[5:4], st.duty_b_lo};
      // Active while counter is within duty+1 counts; zero duty never active
      act_a = (st.duty_a_act != 10'h000) && (st.cnt <= st.duty_a_act);
      act_b = (st.duty_b_act != 10'h000) && (st.cnt <= st.duty_b_act);

      clr_req  = wr && (idx == `TMR_IDX_CTRL) && wb_dat_i[`TMR_CTRL_CLR];
      match_ev = 1'b0;
      ovf_ev   = 1'b0;

      // Counter
      if (clr_req) begin
         // Clear wins over a tick in the same cycle
         next_st.cnt     = 10'h000;
         next_st.cmp_buf = st.cmp;
         next_st.duty_a_act = duty_a_new;
         next_st.duty_b_act = duty_b_new;
      end else if (st.pwm_en) begin
         if (tick) begin
            if (st.cnt >= period) begin
               // Period end: restart and pick up duty values written meanwhile
               next_st.cnt        = 10'h000;
               next_st.duty_a_act = duty_a_new;
               next_st.duty_b_act = duty_b_new;
            end else begin
               next_st.cnt = st.cnt + 10'h001;
            end
         end
      end else if (!st.mode) begin
         if (tick) begin
            if (st.cnt[7:0] == st.cmp_buf) begin
               match_ev        = 1'b1;
               next_st.cnt     = 10'h000;
               next_st.cmp_buf = st.cmp;
            end else begin
               next_st.cnt = {2'b00, st.cnt[7:0] + 8'h01};
            end
         end
      end else begin
         if (cap_edge) begin
            next_st.cnt = 10'h000;
         end else if (tick) begin
            if (st.cnt[7:0] == `TMR_CNT_MAX) begin
               ovf_ev          = 1'b1;
               next_st.cmp_buf = st.cmp;
            end
            next_st.cnt = {2'b00, st.cnt[7:0] + 8'h01};
         end
      end

      if (match_ev) begin
         next_st.toggle = ~st.toggle;
      end

      // Register writes
      if (wr) begin
         case (idx)
            `TMR_IDX_CTRL: begin
               next_st.mode = wb_dat_i[`TMR_CTRL_MODE];
               next_st.cs   = wb_dat_i[3:0];
            end
            `TMR_IDX_CMP: begin
               next_st.cmp = wb_dat_i[7:0];
            end
            `TMR_IDX_PWMCTRL: begin
               next_st.pol_b  = wb_dat_i[`TMR_PWM_POL_B];
               next_st.pol_a  = wb_dat_i[`TMR_PWM_POL_A];
               next_st.pwm_en = wb_dat_i[`TMR_PWM_SEL];
            end
            `TMR_IDX_HBITS: begin
               next_st.hbits = wb_dat_i[7:0];
            end
            `TMR_IDX_DUTY_A: begin
               next_st.duty_a_lo = wb_dat_i[7:0];
            end
            `TMR_IDX_DUTY_B: begin
               next_st.duty_b_lo = wb_dat_i[7:0];
            end
            `TMR_IDX_IRQ: begin
               next_st.mflag = wb_dat_i[`TMR_IRQ_MATCH];
               next_st.oflag = wb_dat_i[`TMR_IRQ_OVF];
            end
            `TMR_IDX_IRQEN: begin
               next_st.men = wb_dat_i[`TMR_IRQ_MATCH];
               next_st.oen = wb_dat_i[`TMR_IRQ_OVF];
            end
            default: begin
               next_st.men = st.men;
            end
         endcase
      end

      // Capture has priority over a bus write of the compare register
      if (!st.pwm_en && st.mode && cap_edge && !clr_req) begin
         next_st.cmp = st.cnt[7:0];
      end

      // Service entry clears a flag, but a new event in that cycle wins
      if (match_irq_ack) begin
         next_st.mflag = 1'b0;
      end
      if (overflow_irq_ack) begin
         next_st.oflag = 1'b0;
      end
      if (match_ev) begin
         next_st.mflag = 1'b1;
      end
      if (ovf_ev) begin
         next_st.oflag = 1'b1;
      end

      // Forwarding depends on the flags as they will stand next cycle
      next_st.mreq = next_st.mflag & next_st.men;
      next_st.oreq = next_st.oflag & next_st.oen;

      // Outputs; outside PWM mode both PWM pins sit at their idle level
      if (st.pwm_en) begin
         next_st.pwm_a = st.pol_a ? act_a : ~act_a;
         next_st.pwm_b = st.pol_b ? act_b : ~act_b;
      end else begin
         next_st.pwm_a = ~st.pol_a;
         next_st.pwm_b = ~st.pol_b;
      end

      // Read data, captured in the cycle the ack rises
      next_st.ack  = req;
      next_st.rdat = 8'h00;
      if (req && !wb_we_i && mapped) begin
         case (idx)
            `TMR_IDX_CTRL: begin
               // Clear bit always reads 0
               next_st.rdat = {2'b00, st.mode, 1'b0, st.cs};
            end
            `TMR_IDX_CMP: begin
               next_st.rdat = st.cmp;
            end
            `TMR_IDX_CNT: begin
               next_st.rdat = st.cnt[7:0];
            end
            `TMR_IDX_PWMCTRL: begin
               next_st.rdat = {1'b0, st.pol_b, st.pol_a, st.pwm_en, 4'h0};
            end
            `TMR_IDX_HBITS: begin
               next_st.rdat = st.hbits;
            end
            `TMR_IDX_DUTY_A: begin
               next_st.rdat = st.duty_a_lo;
            end
            `TMR_IDX_DUTY_B: begin
               next_st.rdat = st.duty_b_lo;
            end
            `TMR_IDX_IRQ: begin
               next_st.rdat = {4'h0, st.mflag, st.oflag, 2'b00};
            end
            `TMR_IDX_IRQEN: begin
               next_st.rdat = {4'h0, st.men, st.oen, 2'b00};
            end
            default: begin
               next_st.rdat = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st            <= '0;
         st.hbits      <= `TMR_RST_HBITS;
         st.cs         <= `TMR_CS_STOP;
         st.duty_a_act <= 10'h3ff;
         st.duty_b_act <= 10'h3ff;
         st.pwm_a      <= 1'b1;
         st.pwm_b      <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o         = {24'h00_0000, st.rdat};
   assign wb_ack_o         = st.ack;
   assign match_toggle_out = st.toggle;
   assign pwm_a_out        = st.pwm_a;
   assign pwm_b_out        = st.pwm_b;
   assign match_irq_req    = st.mreq;
   assign overflow_irq_req = st.oreq;

endmodule

// >>> sim/tmr_top_sva.sv
// Purpose: Port assertions for tmr_top
// Assumes: Shadow bits follow bus writes at the edge that takes them
// Notes:   Flags are hidden, so enables and modes are mirrored here
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_top_sva (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        ext_count_clock,
   input wire logic        capture_input,
   input wire logic        match_irq_ack,
   input wire logic        overflow_irq_ack,
   input wire logic        match_toggle_out,
   input wire logic        pwm_a_out,
   input wire logic        pwm_b_out,
   input wire logic        match_irq_req,
   input wire logic        overflow_irq_req
);
   typedef struct packed {
      logic [7:0] en;
      logic [7:0] pc;
      logic [7:0] ct;
   } tmr_shadow_s;
   tmr_shadow_s sh;
   tmr_shadow_s next_sh;
   logic        wr;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i[11:10] == 2'h0;
   always_comb begin
      next_sh = sh;
      if (wr && wb_adr_i[9:2] == `TMR_IDX_IRQEN) next_sh.en = wb_dat_i[7:0];
      if (wr && wb_adr_i[9:2] == `TMR_IDX_PWMCTRL) next_sh.pc = wb_dat_i[7:0];
      if (wr && wb_adr_i[9:2] == `TMR_IDX_CTRL) next_sh.ct = wb_dat_i[7:0];
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) sh <= '0;
      else sh <= next_sh;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // A match in the ack cycle sets the flag again, so only quiet acks count
   sequence s_match_ack_quiet;
      match_irq_ack && !wr ##1 $stable(match_toggle_out);
   endsequence
   AST_ACK_TAKEN: assert property (s_taken |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_MATCH_GATE: assert property (!sh.en[3] && $past(!sh.en[3]) |-> !match_irq_req)
      else $error("match request while disabled");
   AST_OVF_GATE: assert property (!sh.en[2] && $past(!sh.en[2]) |-> !overflow_irq_req)
      else $error("overflow request while disabled");
   AST_TOGGLE_REQ: assert property ($changed(match_toggle_out) && sh.en[3] |-> match_irq_req)
      else $error("match without request");
   AST_MATCH_CLEAR: assert property (s_match_ack_quiet |-> !match_irq_req)
      else $error("match flag survived service");
   AST_PWM_IDLE: assert property (!sh.pc[4] && $stable(sh.pc) |->
      pwm_a_out == !sh.pc[5] && pwm_b_out == !sh.pc[6])
      else $error("pwm pin not idle");
   AST_CAPTURE_QUIET: assert property (sh.ct[5] && $past(sh.ct[5]) |-> $stable(match_toggle_out))
      else $error("toggle in capture mode");
endmodule
bind tmr_top tmr_top_sva u_tmr_top_sva (
   .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ext_count_clock(ext_count_clock), .capture_input(capture_input),
   .match_irq_ack(match_irq_ack), .overflow_irq_ack(overflow_irq_ack),
   .match_toggle_out(match_toggle_out), .pwm_a_out(pwm_a_out), .pwm_b_out(pwm_b_out),
   .match_irq_req(match_irq_req), .overflow_irq_req(overflow_irq_req)
);

// >>> sim/tmr_pins_model.sv
// Purpose: Pin side: external count clock and capture source
// Assumes: Requests are one-cycle pulses
// Notes:   Count clock stands low between requested pulses
`timescale 1ns/1ps
module tmr_pins_model (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ext_go,
   input  wire logic cap_go,
   output logic      ext_count_clock,
   output logic      capture_input
);
   logic [1:0] eph;
   logic [1:0] cph;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eph <= 2'h0;
         cph <= 2'h0;
      end else begin
         eph <= ext_go ? 2'h3 : eph - 2'(eph != 2'h0);
         cph <= cap_go ? 2'h3 : cph - 2'(cph != 2'h0);
      end
   end
   // Two cycles high, two low: slow enough for the sampled edge detector
   assign ext_count_clock = eph[1];
   assign capture_input   = cph[1];
endmodule

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for tmr_top
// Assumes: Reads are checked in order by a monitor
// Notes:   Pin checks count levels over whole periods
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tb_top;
   logic        clk, nrst, cyc, stb, we, ext_go, cap_go, m_ack, o_ack;
   logic        ack, ext_clk, cap_in, tog, pa, pb, m_req, o_req;
   logic [11:0] adr;
   logic [31:0] dat, rdat;
   logic [15:0] exp_q[$];
   int          mismatches, compares, ha, hb, tg, n, cmpv;
   int          dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
   integer      seed;
   tmr_top u_tmr_top (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ext_count_clock(ext_clk), .capture_input(cap_in), .match_irq_ack(m_ack),
      .overflow_irq_ack(o_ack), .match_toggle_out(tog), .pwm_a_out(pa), .pwm_b_out(pb),
      .match_irq_req(m_req), .overflow_irq_req(o_req));
   tmr_pins_model u_tmr_pins_model (.clk(clk), .nrst(nrst), .ext_go(ext_go), .cap_go(cap_go),
      .ext_count_clock(ext_clk), .capture_input(cap_in));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'h0, idx, 2'h0};
      dat <= 32'(d);
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(idx, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      exp_q.push_back(16'(e));
      bus(idx, 1'b0, 8'h00);
   endtask
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk(16'(rdat[7:0]), exp_q.pop_front());
   end
   task automatic meas(input int cyc_n);
      logic t0;
      ha = 0;
      hb = 0;
      tg = 0;
      t0 = tog;
      repeat (cyc_n) begin
         @(posedge clk);
         ha += (pa === 1'b1);
         hb += (pb === 1'b1);
         tg += (tog !== t0);
         t0 = tog;
      end
   endtask
   task automatic irq_ack(input bit m);
      @(posedge clk);
      if (m) m_ack <= 1'b1;
      else o_ack <= 1'b1;
      @(posedge clk);
      m_ack <= 1'b0;
      o_ack <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic pin_pulse(input bit e);
      @(posedge clk);
      if (e) ext_go <= 1'b1;
      else cap_go <= 1'b1;
      @(posedge clk);
      ext_go <= 1'b0;
      cap_go <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   initial begin
      {cyc, stb, we, ext_go, cap_go, m_ack, o_ack, nrst} = 8'h00;
      adr = 12'h000;
      dat = 32'h0000_0000;
      seed = 96746;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd(`TMR_IDX_CTRL, `TMR_RST_CTRL);
      rd(`TMR_IDX_HBITS, `TMR_RST_HBITS);
      rd(8'h40, 8'h00);
      cmpv = 2 + ({$random(seed)} % 8);
      wr(`TMR_IDX_CMP, 8'(cmpv));
      wr(`TMR_IDX_IRQEN, 8'h08);
      wr(`TMR_IDX_CTRL, 8'h18);
      meas(4 * (cmpv + 1));
      chk(16'(tg), 16'h0004);
      wr(`TMR_IDX_IRQEN, 8'h00);
      chk(16'(m_req), 16'h0000);
      wr(`TMR_IDX_CTRL, 8'h00);
      wr(`TMR_IDX_IRQEN, 8'h08);
      repeat (2) @(posedge clk);
      chk(16'(m_req), 16'h0001);
      irq_ack(1'b1);
      chk(16'(m_req), 16'h0000);
      wr(`TMR_IDX_CTRL, 8'h10);
      rd(`TMR_IDX_CNT, 8'h00);
      rd(`TMR_IDX_CTRL, 8'h00);
      wr(`TMR_IDX_CMP, 8'hff);
      // Any 4*d consecutive edges hold exactly four prescaler ticks
      for (int i = 0; i < 8; i++) begin
         wr(`TMR_IDX_CTRL, 8'h18 + 8'(i));
         repeat (4 * dv[i] - 3) @(posedge clk);
         wr(`TMR_IDX_CTRL, 8'h00);
         rd(`TMR_IDX_CNT, 8'h04);
      end
      for (int c = 5; c < 7; c++) begin
         n = 1 + ({$random(seed)} % 6);
         wr(`TMR_IDX_CTRL, 8'h30 + 8'(c));
         repeat (n) pin_pulse(1'b1);
         rd(`TMR_IDX_CNT, 8'(n));
         pin_pulse(1'b0);
         rd(`TMR_IDX_CMP, 8'(n));
         rd(`TMR_IDX_CNT, 8'h00);
      end
      wr(`TMR_IDX_IRQEN, 8'h04);
      wr(`TMR_IDX_CTRL, 8'h38);
      for (int k = 0; k < 300 && o_req !== 1'b1; k++) @(posedge clk);
      chk(16'(o_req), 16'h0001);
      rd(`TMR_IDX_IRQ, 8'h04);
      wr(`TMR_IDX_CTRL, 8'h20);
      wr(`TMR_IDX_IRQEN, 8'h00);
      chk(16'(o_req), 16'h0000);
      irq_ack(1'b0);
      rd(`TMR_IDX_IRQ, 8'h00);
      wr(`TMR_IDX_IRQEN, 8'h04);
      repeat (2) @(posedge clk);
      chk(16'(o_req), 16'h0000);
      wr(`TMR_IDX_CTRL, 8'h00);
      wr(`TMR_IDX_CMP, 8'h09);
      wr(`TMR_IDX_HBITS, 8'h00);
      wr(`TMR_IDX_DUTY_A, 8'h03);
      wr(`TMR_IDX_DUTY_B, 8'h00);
      wr(`TMR_IDX_PWMCTRL, 8'h70);
      rd(`TMR_IDX_PWMCTRL, 8'h70);
      wr(`TMR_IDX_CTRL, 8'h18);
      repeat (20) @(posedge clk);
      meas(30);
      chk(16'(ha), 16'h000c);
      chk(16'(hb), 16'h0000);
      wr(`TMR_IDX_PWMCTRL, 8'h10);
      repeat (10) @(posedge clk);
      meas(30);
      chk(16'(ha), 16'h0012);
      chk(16'(hb), 16'h001e);
      wr(`TMR_IDX_PWMCTRL, 8'h70);
      wr(`TMR_IDX_DUTY_A, 8'h09);
      repeat (20) @(posedge clk);
      meas(30);
      chk(16'(ha), 16'h001e);
      wr(`TMR_IDX_DUTY_A, 8'h05);
      wr(`TMR_IDX_DUTY_B, 8'h01);
      repeat (20) @(posedge clk);
      wr(`TMR_IDX_CMP, 8'h13);
      repeat (40) @(posedge clk);
      meas(40);
      chk(16'(ha), 16'h000c);
      chk(16'(hb), 16'h0004);
      wr(`TMR_IDX_HBITS, 8'h15);
      repeat (600) @(posedge clk);
      meas(276);
      chk(16'(ha), 16'h0106);
      chk(16'(hb), 16'h0102);
      give_verdict();
   end
   initial begin
      #400000;
      mismatches++;
      give_verdict();
   end
endmodule
